// [include/tcr_pkg.sv]
package tcr_pkg;

	localparam int unsigned CNT_W = 8;

	// Register byte addresses on the plain register port
	localparam logic [7:0] ADDR_RELOAD = 8'hCD;
	localparam logic [7:0] ADDR_COUNT  = 8'hDB;
	localparam logic [7:0] ADDR_MODE   = 8'hE0;
	localparam logic [7:0] ADDR_CLKSEL = 8'hE1;
	localparam logic [7:0] ADDR_STATUS = 8'hE2;
	localparam logic [7:0] ADDR_MASK   = 8'hE3;

	// Mode, clock select and status register field positions
	localparam int unsigned MODE_PWM_BIT = 0;
	localparam int unsigned MODE_TGL_BIT = 1;
	localparam int unsigned MODE_ARL_BIT = 2;
	localparam int unsigned MODE_SRC_BIT = 3;
	localparam int unsigned MODE_PRE_LSB = 4;
	localparam int unsigned MODE_RUN_BIT = 7;
	localparam int unsigned CLKSEL_FAST_BIT = 0;
	localparam int unsigned STS_OVF_BIT = 0;

	// Values after reset
	localparam logic [7:0] RST_COUNT  = 8'h00;
	localparam logic [7:0] RST_RELOAD = 8'h00;
	localparam logic [7:0] RST_MODE   = 8'h00;
	localparam logic [7:0] RST_REG    = 8'h00;
	localparam logic       RST_PIN    = 1'b0;

	// Overflow boundaries expressed as masks of the significant count bits
	localparam logic [7:0] MASK_256 = 8'hFF;
	localparam logic [7:0] MASK_64  = 8'h3F;
	localparam logic [7:0] MASK_32  = 8'h1F;
	localparam logic [7:0] MASK_16  = 8'h0F;

	// Prescaler masks for prescale code zero
	localparam logic [7:0] PRE_SLOW_MASK = 8'hFF;
	localparam logic [7:0] PRE_FAST_MASK = 8'h7F;

	typedef struct packed {
		logic       timer_run_enable;
		logic [2:0] prescale_code;
		logic       count_source_select;
		logic       auto_reload_select;
		logic       toggle_output_select;
		logic       pwm_output_enable;
	} tcr_mode_s;

	function automatic logic [7:0] tcr_bound_mask(input tcr_mode_s m);
		logic [7:0] r;
		r = MASK_256;
		if (!m.count_source_select && m.pwm_output_enable)
		begin
			unique case ({m.auto_reload_select, m.toggle_output_select})
				2'b00: r = MASK_256;
				2'b01: r = MASK_64;
				2'b10: r = MASK_32;
				2'b11: r = MASK_16;
			endcase
		end
		return r;
	endfunction : tcr_bound_mask

endpackage : tcr_pkg

// [rtl/tcr_prescaler.sv]
`timescale 1ns/1ps
module tcr_prescaler #(
	parameter int unsigned PRE_W = 8
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       fcpu_tick_i,
	input  wire logic       fosc_tick_i,
	input  wire logic       fast_clock_select_i,
	input  wire logic [2:0] prescale_code_i,
	output logic            tick_o
);

	if (PRE_W != 8)
	begin : g_chk
		$error("tcr_prescaler: PRE_W must be 8");
	end

	logic [PRE_W-1:0] div_q;
	logic [PRE_W-1:0] div_d;
	wire logic             base_w;
	wire logic [PRE_W-1:0] mask_w;

	// Fast source divides one step less, so code 111 gives the raw oscillator tick
	assign base_w = fast_clock_select_i ? fosc_tick_i : fcpu_tick_i;
	assign mask_w = fast_clock_select_i ? (tcr_pkg::PRE_FAST_MASK >> prescale_code_i)
	                                    : (tcr_pkg::PRE_SLOW_MASK >> prescale_code_i);
	assign div_d  = base_w ? div_q + PRE_W'(1) : div_q;
	assign tick_o = base_w && ((div_q & mask_w) == mask_w);

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			div_q <= tcr_pkg::RST_REG;
		else
			div_q <= div_d;
	end

endmodule : tcr_prescaler

// [rtl/tcr_fall_detect.sv]
`timescale 1ns/1ps
module tcr_fall_detect (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic level_i,
	output logic      fall_o
);

	logic prev_q;

	// Reset low so that a pin idling low gives no edge after reset
	assign fall_o = prev_q && !level_i;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			prev_q <= tcr_pkg::RST_PIN;
		else
			prev_q <= level_i;
	end

endmodule : tcr_fall_detect

// [rtl/tcr_core.sv]
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module tcr_core #(
	parameter int unsigned CNT_W = tcr_pkg::CNT_W
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic [7:0]       bus_addr_i,
	input  wire logic [7:0]       bus_wdata_i,
	input  wire logic             bus_wr_i,
	input  wire logic             bus_rd_i,
	output logic      [7:0]       bus_rdata_o,
	input  wire logic             fcpu_tick_i,
	input  wire logic             fosc_tick_i,
	input  wire logic             external_count_input_i,
	output logic                  irq_o,
	output logic                  timeout_o,
	output logic      [CNT_W-1:0] timer_count_value_o,
	output logic      [CNT_W-1:0] reload_active_o
);

	if (CNT_W != 8)
	begin : g_chk
		$error("tcr_core: CNT_W must be 8");
	end

	// Register state
	logic      [CNT_W-1:0] count_q;
	logic      [CNT_W-1:0] count_d;
	logic      [CNT_W-1:0] hold_q;
	logic      [CNT_W-1:0] hold_d;
	logic      [CNT_W-1:0] active_q;
	logic      [CNT_W-1:0] active_d;
	tcr_pkg::tcr_mode_s    mode_q;
	logic                  fast_q;
	logic      [7:0]       sts_q;
	logic      [7:0]       sts_d;
	logic      [7:0]       mask_q;
	logic      [7:0]       rdata_q;
	logic      [7:0]       rdata_d;
	logic                  timeout_q;
	logic                  irq_q;

	// Decode
	wire logic             wr_count_w;
	wire logic             wr_reload_w;
	wire logic             wr_mode_w;
	wire logic             wr_clksel_w;
	wire logic             wr_status_w;
	wire logic             wr_mask_w;
	wire logic             pre_tick_w;
	wire logic             ext_fall_w;
	wire logic             tick_w;
	wire logic             ovf_w;
	wire logic             reload_en_w;
	wire logic [CNT_W-1:0] bound_w;
	wire logic [CNT_W-1:0] inc_w;
	wire logic [CNT_W-1:0] wrap_w;
	wire logic [7:0]       rd_mux_w;

	assign wr_count_w  = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_COUNT);
	assign wr_reload_w = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_RELOAD);
	assign wr_mode_w   = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_MODE);
	assign wr_clksel_w = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_CLKSEL);
	assign wr_status_w = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_STATUS);
	assign wr_mask_w   = bus_wr_i && (bus_addr_i == tcr_pkg::ADDR_MASK);

	tcr_prescaler #(
		.PRE_W (8)
	) u_pre (
		.mclk_i              (mclk_i),
		.rst_n_i             (rst_n_i),
		.fcpu_tick_i         (fcpu_tick_i),
		.fosc_tick_i         (fosc_tick_i),
		.fast_clock_select_i (fast_q),
		.prescale_code_i     (mode_q.prescale_code),
		.tick_o              (pre_tick_w)
	);

	tcr_fall_detect u_fall (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.level_i (external_count_input_i),
		.fall_o  (ext_fall_w)
	);

	// Tick source and run gate
	assign tick_w = mode_q.timer_run_enable &&
	                (mode_q.count_source_select ? ext_fall_w : pre_tick_w);

	// Boundary: only the masked low bits count; upper bits are left untouched
	assign bound_w = tcr_pkg::tcr_bound_mask(mode_q);
	assign ovf_w   = tick_w && ((count_q & bound_w) == bound_w);
	assign inc_w   = count_q + CNT_W'(1);
	assign wrap_w  = (count_q & ~bound_w) | (inc_w & bound_w);

	// PWM forces reload; otherwise the reload select decides
	assign reload_en_w = mode_q.pwm_output_enable || mode_q.auto_reload_select;

	// Software write wins over a tick in the same cycle
	always_comb
	begin
		count_d = count_q;
		if (wr_count_w)
			count_d = bus_wdata_i;
		else if (ovf_w && reload_en_w)
			count_d = hold_q;
		else if (tick_w)
			count_d = wrap_w;
	end

	// Overflow loads the value being promoted, so a write made before it is used
	assign hold_d   = wr_reload_w ? bus_wdata_i : hold_q;
	assign active_d = ovf_w ? hold_q : active_q;

	// Set beats a write-one clear in the same cycle
	assign sts_d = (sts_q & ~(wr_status_w ? bus_wdata_i : tcr_pkg::RST_REG)) |
	               ({7'h00, ovf_w} << tcr_pkg::STS_OVF_BIT);

	// Reload register is write-only and reads back as zero
	assign rd_mux_w = (bus_addr_i == tcr_pkg::ADDR_COUNT)  ? count_q :
	                  (bus_addr_i == tcr_pkg::ADDR_MODE)   ? mode_q :
	                  (bus_addr_i == tcr_pkg::ADDR_CLKSEL) ? {7'h00, fast_q} :
	                  (bus_addr_i == tcr_pkg::ADDR_STATUS) ? sts_q :
	                  (bus_addr_i == tcr_pkg::ADDR_MASK)   ? mask_q :
	                  tcr_pkg::RST_REG;
	assign rdata_d = bus_rd_i ? rd_mux_w : tcr_pkg::RST_REG;

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count_q  <= tcr_pkg::RST_COUNT;
			hold_q   <= tcr_pkg::RST_RELOAD;
			active_q <= tcr_pkg::RST_RELOAD;
		end
		else
		begin
			count_q  <= count_d;
			hold_q   <= hold_d;
			active_q <= active_d;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode_q <= tcr_pkg::RST_MODE;
			fast_q <= 1'b0;
			mask_q <= tcr_pkg::RST_REG;
		end
		else
		begin
			if (wr_mode_w)
				mode_q <= bus_wdata_i;
			if (wr_clksel_w)
				fast_q <= bus_wdata_i[tcr_pkg::CLKSEL_FAST_BIT];
			if (wr_mask_w)
				mask_q <= bus_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sts_q     <= tcr_pkg::RST_REG;
			rdata_q   <= tcr_pkg::RST_REG;
			timeout_q <= 1'b0;
			irq_q     <= 1'b0;
		end
		else
		begin
			sts_q     <= sts_d;
			rdata_q   <= rdata_d;
			timeout_q <= ovf_w;
			irq_q     <= |(sts_d & mask_q);
		end
	end

	assign bus_rdata_o         = rdata_q;
	assign irq_o               = irq_q;
	assign timeout_o           = timeout_q;
	assign timer_count_value_o = count_q;
	assign reload_active_o     = active_q;

	// Checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_overflow;
		ovf_w && !wr_count_w;
	endsequence

	sequence s_reloaded;
		count_q == $past(hold_q);
	endsequence

	property p_count_write;
		wr_count_w |=> count_q == $past(bus_wdata_i);
	endproperty
	a_count_write: assert property (p_count_write) else $error("count write lost");

	property p_count_read;
		bus_rd_i && (bus_addr_i == tcr_pkg::ADDR_COUNT) |=> bus_rdata_o == $past(count_q);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_reload_reads_zero;
		bus_rd_i && (bus_addr_i == tcr_pkg::ADDR_RELOAD) |=> bus_rdata_o == 8'h00;
	endproperty
	a_reload_reads_zero: assert property (p_reload_reads_zero) else $error("reload readable");

	property p_full_boundary;
		tick_w && (mode_q.count_source_select || !mode_q.pwm_output_enable ||
		           !(mode_q.auto_reload_select || mode_q.toggle_output_select))
		|-> (ovf_w == (count_q == 8'hFF));
	endproperty
	a_full_boundary: assert property (p_full_boundary) else $error("256 boundary wrong");

	property p_pwm_boundary;
		tick_w && !mode_q.count_source_select && mode_q.pwm_output_enable &&
		!mode_q.auto_reload_select && mode_q.toggle_output_select
		|-> (ovf_w == (count_q[5:0] == 6'h3F));
	endproperty
	a_pwm_boundary: assert property (p_pwm_boundary) else $error("64 boundary wrong");

	property p_ext_boundary;
		tick_w && mode_q.count_source_select && (count_q != 8'hFF) |-> !ovf_w;
	endproperty
	a_ext_boundary: assert property (p_ext_boundary) else $error("event count wrap");

	property p_auto_reload;
		(s_overflow and mode_q.auto_reload_select) |=> s_reloaded;
	endproperty
	a_auto_reload: assert property (p_auto_reload) else $error("reload missed");

	property p_pwm_reload;
		(s_overflow and mode_q.pwm_output_enable) |=> s_reloaded;
	endproperty
	a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload missed");

	property p_hold_move;
		ovf_w |=> reload_active_o == $past(hold_q);
	endproperty
	a_hold_move: assert property (p_hold_move) else $error("active not promoted");

	property p_hold_still;
		!ovf_w |=> $stable(reload_active_o);
	endproperty
	a_hold_still: assert property (p_hold_still) else $error("active changed early");

	property p_stopped;
		!mode_q.timer_run_enable && !wr_count_w |=> $stable(count_q);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_ext_edge;
		mode_q.timer_run_enable && mode_q.count_source_select && ext_fall_w &&
		!reload_en_w && !wr_count_w |=> count_q == 8'($past(count_q) + 1'b1);
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("edge not counted");

	property p_timeout_irq;
		ovf_w |=> timeout_o && sts_q[tcr_pkg::STS_OVF_BIT] ##1 (!timeout_o || $past(ovf_w));
	endproperty
	a_timeout_irq: assert property (p_timeout_irq) else $error("time-out not raised");

	property p_slow_div2;
		!fast_q && (mode_q.prescale_code == 3'b111) && pre_tick_w |-> fcpu_tick_i;
	endproperty
	a_slow_div2: assert property (p_slow_div2) else $error("tick without base");

	property p_fast_div1;
		fast_q && (mode_q.prescale_code == 3'b111) |-> (pre_tick_w == fosc_tick_i);
	endproperty
	a_fast_div1: assert property (p_fast_div1) else $error("fast divide by one wrong");

	// Narrow boundaries only look at the low count bits
	property p_pwm32_boundary;
		tick_w && !mode_q.count_source_select && mode_q.pwm_output_enable &&
		mode_q.auto_reload_select && !mode_q.toggle_output_select
		|-> (ovf_w == (count_q[4:0] == 5'h1F));
	endproperty
	a_pwm32_boundary: assert property (p_pwm32_boundary) else $error("32 boundary wrong");

	property p_pwm16_boundary;
		tick_w && !mode_q.count_source_select && mode_q.pwm_output_enable &&
		mode_q.auto_reload_select && mode_q.toggle_output_select
		|-> (ovf_w == (count_q[3:0] == 4'hF));
	endproperty
	a_pwm16_boundary: assert property (p_pwm16_boundary) else $error("16 boundary wrong");

	property p_count_up;
		tick_w && !ovf_w && !wr_count_w |=> count_q == 8'($past(count_q) + 1'b1);
	endproperty
	a_count_up: assert property (p_count_up) else $error("count did not step");

	// Without reload the wrap clears the low bits and keeps the upper ones
	property p_wrap_keep;
		(s_overflow and !reload_en_w) |=> count_q == ($past(count_q) & ~$past(bound_w));
	endproperty
	a_wrap_keep: assert property (p_wrap_keep) else $error("wrap value wrong");

	property p_rld_quiet;
		wr_reload_w && !tick_w |=> $stable(count_q);
	endproperty
	a_rld_quiet: assert property (p_rld_quiet) else $error("reload write moved count");

	property p_status_clear;
		wr_status_w && bus_wdata_i[tcr_pkg::STS_OVF_BIT] && !ovf_w
		|=> !sts_q[tcr_pkg::STS_OVF_BIT];
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared");

	property p_status_sticky;
		sts_q[tcr_pkg::STS_OVF_BIT] && !wr_status_w |=> sts_q[tcr_pkg::STS_OVF_BIT];
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("status lost");

	property p_irq_needs_status;
		irq_o |-> (|sts_q);
	endproperty
	a_irq_needs_status: assert property (p_irq_needs_status) else $error("irq without status");

	property p_rdata_idle;
		!bus_rd_i |=> bus_rdata_o == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_mode_write;
		wr_mode_w |=> mode_q.timer_run_enable == $past(bus_wdata_i[tcr_pkg::MODE_RUN_BIT]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("run enable not written");

endmodule : tcr_core

// [bench/test_timer0_count_reload_core.sv]
`timescale 1ns/1ps
module test_timer0_count_reload_core;
	logic       mclk_i;
	logic       rst_n_i;
	logic [7:0] bus_addr_i;
	logic [7:0] bus_wdata_i;
	logic       bus_wr_i;
	logic       bus_rd_i;
	logic [7:0] bus_rdata_o;
	logic       fcpu_tick_i;
	logic       fosc_tick_i;
	logic       external_count_input_i;
	logic       irq_o;
	logic       timeout_o;
	logic [7:0] timer_count_value_o;
	logic [7:0] reload_active_o;
	logic [1:0] div_q;
	int         err_count;
	int         samples_checked;
	logic [7:0] rv;
	int         n;
	// Boundary cases as {auto reload, toggle select, pwm enable}
	logic [2:0] bsel [6] = '{3'b000, 3'b100, 3'b001, 3'b011, 3'b101, 3'b111};
	logic [7:0] brld [6] = '{8'h40, 8'h40, 8'h10, 8'h10, 8'h08, 8'h04};
	logic [7:0] bcnt [6] = '{8'h00, 8'h40, 8'h10, 8'h10, 8'h08, 8'h04};
	int         bper [6] = '{256, 192, 240, 48, 24, 12};

	tcr_core u_dut (
		.mclk_i                 (mclk_i),
		.rst_n_i                (rst_n_i),
		.bus_addr_i             (bus_addr_i),
		.bus_wdata_i            (bus_wdata_i),
		.bus_wr_i               (bus_wr_i),
		.bus_rd_i               (bus_rd_i),
		.bus_rdata_o            (bus_rdata_o),
		.fcpu_tick_i            (fcpu_tick_i),
		.fosc_tick_i            (fosc_tick_i),
		.external_count_input_i (external_count_input_i),
		.irq_o                  (irq_o),
		.timeout_o              (timeout_o),
		.timer_count_value_o    (timer_count_value_o),
		.reload_active_o        (reload_active_o)
	);

	always #50 mclk_i = ~mclk_i;

	// Instruction clock at a quarter of the oscillator rate, so the two sources differ
	always @(posedge mclk_i)
	begin
		div_q <= div_q + 2'd1;
		fcpu_tick_i <= (div_q == 2'd3);
	end

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk8

	task automatic chk1(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk1

	task automatic chkn(input int got, input int exp, input string what);
		samples_checked++;
		if (got != exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask : chkn

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		bus_addr_i <= a;
		bus_wdata_i <= d;
		bus_wr_i <= 1'b1;
		@(posedge mclk_i);
		bus_wr_i <= 1'b0;
		@(negedge mclk_i);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		bus_addr_i <= a;
		bus_rd_i <= 1'b1;
		@(posedge mclk_i);
		bus_rd_i <= 1'b0;
		@(negedge mclk_i);
		d = bus_rdata_o;
	endtask : reg_rd

	// Cycles until the next time-out pulse; a lost pulse counts as a mismatch
	task automatic wait_to(output int cyc);
		cyc = 0;
		do
		begin
			@(negedge mclk_i);
			cyc++;
		end
		while (timeout_o !== 1'b1 && cyc < 2000);
		if (cyc >= 2000)
			chk1(timeout_o, 1'b1, "time-out never came");
	endtask : wait_to

	task automatic step_gap(output int cyc);
		logic [7:0] v;
		v = timer_count_value_o;
		cyc = 0;
		do
		begin
			@(negedge mclk_i);
			cyc++;
		end
		while (timer_count_value_o === v && cyc < 3000);
	endtask : step_gap

	task automatic pin_fall();
		@(posedge mclk_i);
		external_count_input_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		external_count_input_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
	endtask : pin_fall

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial
	begin
		#5_000_000;
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict();
	end

	initial
	begin
		mclk_i = 1'b0;
		rst_n_i = 1'b0;
		bus_addr_i = 8'h00;
		bus_wdata_i = 8'h00;
		bus_wr_i = 1'b0;
		bus_rd_i = 1'b0;
		fcpu_tick_i = 1'b0;
		fosc_tick_i = 1'b1;
		external_count_input_i = 1'b0;
		div_q = 2'd0;
		err_count = 0;
		samples_checked = 0;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		reg_rd(tcr_pkg::ADDR_COUNT, rv);
		chk8(rv, 8'h00, "count after reset");
		reg_rd(tcr_pkg::ADDR_RELOAD, rv);
		chk8(rv, 8'h00, "reload reads back");
		chk8(reload_active_o, 8'h00, "active reload after reset");
		reg_wr(8'h10, 8'h5A);
		reg_rd(8'h10, rv);
		chk8(rv, 8'h00, "unmapped read");
		reg_wr(tcr_pkg::ADDR_COUNT, 8'hA5);
		chk8(timer_count_value_o, 8'hA5, "count write at once");
		reg_rd(tcr_pkg::ADDR_COUNT, rv);
		chk8(rv, 8'hA5, "count read back");
		@(negedge mclk_i);
		chk8(bus_rdata_o, 8'h00, "read data one cycle");
		// Every prescale code on both sources; the first gap after a change may be short
		for (int c = 0; c < 8; c++)
		begin
			for (int f = 0; f < 2; f++)
			begin
				reg_wr(tcr_pkg::ADDR_CLKSEL, {7'd0, f[0]});
				reg_wr(tcr_pkg::ADDR_MODE, {1'b1, c[2:0], 4'b0000});
				step_gap(n);
				step_gap(n);
				chkn(n, (f == 1) ? (1 << (7 - c)) : (4 << (8 - c)), "tick gap");
			end
		end
		// Fastest tick: one count per cycle, so the pulse period equals boundary minus reload, or the whole boundary when reload is off
		reg_wr(tcr_pkg::ADDR_CLKSEL, 8'h01);
		for (int i = 0; i < 6; i++)
		begin
			reg_wr(tcr_pkg::ADDR_RELOAD, brld[i]);
			reg_wr(tcr_pkg::ADDR_MODE, {1'b1, 3'b111, 1'b0, bsel[i]});
			wait_to(n);
			wait_to(n);
			chkn(n, bper[i], "overflow period");
			chk8(timer_count_value_o, bcnt[i], "count after overflow");
			chk8(reload_active_o, brld[i], "active reload");
			@(negedge mclk_i);
			chk1(timeout_o, 1'b0, "time-out one cycle");
		end
		reg_wr(tcr_pkg::ADDR_MODE, 8'h00);
		reg_wr(tcr_pkg::ADDR_RELOAD, 8'h77);
		repeat (3) @(negedge mclk_i);
		chk8(reload_active_o, 8'h04, "held reload not promoted");
		reg_wr(tcr_pkg::ADDR_COUNT, 8'h20);
		repeat (40) @(negedge mclk_i);
		chk8(timer_count_value_o, 8'h20, "stopped count");
		reg_wr(tcr_pkg::ADDR_MASK, 8'h00);
		reg_wr(tcr_pkg::ADDR_STATUS, 8'h01);
		repeat (2) @(negedge mclk_i);
		chk1(irq_o, 1'b0, "irq after clear");
		// External pin with PWM selects 11 set: the boundary must stay at 256
		reg_wr(tcr_pkg::ADDR_RELOAD, 8'h00);
		reg_wr(tcr_pkg::ADDR_COUNT, 8'h0E);
		reg_wr(tcr_pkg::ADDR_MODE, 8'h8F);
		reg_rd(tcr_pkg::ADDR_MODE, rv);
		chk8(rv, 8'h8F, "mode read back");
		reg_rd(tcr_pkg::ADDR_CLKSEL, rv);
		chk8(rv, 8'h01, "clock select read back");
		pin_fall();
		pin_fall();
		chk8(timer_count_value_o, 8'h10, "event count past 16");
		reg_rd(tcr_pkg::ADDR_STATUS, rv);
		chk8(rv, 8'h00, "no overflow below 256");
		reg_wr(tcr_pkg::ADDR_COUNT, 8'hFF);
		pin_fall();
		chk8(timer_count_value_o, 8'h00, "event wrap");
		chk8(reload_active_o, 8'h00, "promoted on event overflow");
		reg_rd(tcr_pkg::ADDR_STATUS, rv);
		chk8(rv, 8'h01, "overflow status");
		chk1(irq_o, 1'b0, "masked irq");
		reg_wr(tcr_pkg::ADDR_MASK, 8'h01);
		reg_rd(tcr_pkg::ADDR_MASK, rv);
		chk8(rv, 8'h01, "mask read back");
		repeat (2) @(negedge mclk_i);
		chk1(irq_o, 1'b1, "unmasked irq");
		reg_wr(tcr_pkg::ADDR_STATUS, 8'h01);
		repeat (2) @(negedge mclk_i);
		chk1(irq_o, 1'b0, "irq cleared");
		give_verdict();
	end
endmodule : test_timer0_count_reload_core
